// >>> verilog/burst_sram.sv
// synchronous pipelined burst static memory core
`timescale 1ns/1ps
`include "burst_sram_cfg.svh"
module burst_sram
   import burst_sram_pkg::*;
(
   input  wire logic                    CLK,        // clock
   input  wire logic                    NRST,       // sync reset, low
   input  wire logic [`SRAM_ADDR_W-1:0] ADDR,       // address inputs
   input  wire logic                    CPU_ADDR_STROBE_N,  // proc strobe
   input  wire logic                    CTRL_ADDR_STROBE_N, // ctrl strobe
   input  wire logic                    BURST_ADVANCE_N,    // advance
   input  wire logic                    GLOBAL_WRITE_N,     // all lanes
   input  wire logic                    BYTE_WRITE_GATE_N,  // lane gate
   input  wire logic [`SRAM_LANES-1:0]  LANE_WRITE_N,       // lane writes
   input  wire logic                    PRIMARY_SELECT_N,   // select 1
   input  wire logic                    SECONDARY_SELECT,   // select 2
   input  wire logic                    TERTIARY_SELECT_N,  // select 3
   input  wire logic                    OUT_ENABLE_N,       // async oe
   input  wire logic                    BURST_ORDER_SEL,    // 1 interleave
   input  wire logic                    SLEEP_REQ,          // power down
   input  wire logic [`SRAM_DATA_W-1:0] DQ_IN,      // data from bus
   output logic      [`SRAM_DATA_W-1:0] DQ_OUT,     // read data
   output logic                         DQ_OE,      // drive enable
   output logic                         ASLEEP      // power-down status
);
   timeunit 1ns;
   // ==============================================================
   // input registers
   logic [`SRAM_ADDR_W-1:0] r_addr;
   logic r_cpu_addr_strobe_n_n, r_ctrl_addr_strobe_n_n, r_adv_n, r_gw_n, r_bw_n;
   logic [`SRAM_LANES-1:0] r_we_n;
   logic r_cs1_n, r_cs2, r_cs3_n;
   logic [`SRAM_DATA_W-1:0] r_din;

   // capture address and control each edge
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         r_addr   <= '0;
         r_cpu_addr_strobe_n_n <= 1'b1;
         r_ctrl_addr_strobe_n_n <= 1'b1;
         r_adv_n  <= 1'b1;
         r_gw_n   <= 1'b1;
         r_bw_n   <= 1'b1;
         r_we_n   <= '1;
         r_cs1_n  <= 1'b1;
         r_cs2    <= 1'b0;
         r_cs3_n  <= 1'b1;
         r_din    <= '0;
      end else begin
         r_addr   <= ADDR;
         r_cpu_addr_strobe_n_n <= CPU_ADDR_STROBE_N;
         r_ctrl_addr_strobe_n_n <= CTRL_ADDR_STROBE_N;
         r_adv_n  <= BURST_ADVANCE_N;
         r_gw_n   <= GLOBAL_WRITE_N;
         r_bw_n   <= BYTE_WRITE_GATE_N;
         r_we_n   <= LANE_WRITE_N;
         r_cs1_n  <= PRIMARY_SELECT_N;
         r_cs2    <= SECONDARY_SELECT;
         r_cs3_n  <= TERTIARY_SELECT_N;
         r_din    <= DQ_IN;
      end
   end

   // ==============================================================
   // power-down sequencing
   pwr_state_t pwr;
   logic [1:0] wake_cnt;
   wire  awake = (pwr == ST_IDLE) && !SLEEP_REQ;

   // sleep entry and two-cycle wake-up
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         pwr      <= ST_IDLE;
         wake_cnt <= 2'h0;
      end else begin
         case (pwr)
            ST_IDLE:  if (SLEEP_REQ) pwr <= ST_SLEEP;
            ST_SLEEP: if (!SLEEP_REQ) begin
               pwr      <= ST_WAKE;
               wake_cnt <= 2'h1;
            end
            ST_WAKE: begin
               if (SLEEP_REQ) pwr <= ST_SLEEP;
               else if (wake_cnt == `SRAM_WAKE_CYC) pwr <= ST_IDLE;
               else wake_cnt <= 2'(wake_cnt + 2'h1);
            end
            default: pwr <= ST_IDLE;
         endcase
      end
   end
   assign ASLEEP = (pwr != ST_IDLE) || SLEEP_REQ;

   // ==============================================================
   // cycle start decode
   wire sel_ok    = !r_cs1_n && r_cs2 && !r_cs3_n;
   wire cpu_addr_strobe_n_go   = !r_cpu_addr_strobe_n_n && !r_cs1_n;
   wire ctrl_addr_strobe_n_go   = !r_ctrl_addr_strobe_n_n && r_cpu_addr_strobe_n_n;
   wire start     = awake && (cpu_addr_strobe_n_go || ctrl_addr_strobe_n_go);
   wire start_sel = start && sel_ok;
   wire deselect  = awake && start && !sel_ok;
   logic active;                                            // burst selected
   logic cpu_addr_strobe_n_edge;                                         // cpu_addr_strobe_n start

   // lane write enables; ignored on processor strobe start edge
   wire [`SRAM_LANES-1:0] lane_wr =
      !r_gw_n ? {`SRAM_LANES{1'b1}}
              : (r_bw_n ? '0 : ~r_we_n);
   wire wr_ok  = awake && (start ? sel_ok : active) &&
                 !(start && !r_cpu_addr_strobe_n_n);
   wire any_wr = wr_ok && |lane_wr;
   wire step   = awake && active && !start && !r_adv_n;

   // selection state
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         active    <= 1'b0;
         cpu_addr_strobe_n_edge <= 1'b0;
      end else if (awake) begin
         if (start) active <= sel_ok;
         cpu_addr_strobe_n_edge <= start && !r_cpu_addr_strobe_n_n;
      end
   end

   logic [`SRAM_ADDR_W-1:0] cur_addr;
   burst_addr_gen u_gen (
      .clk        (CLK),
      .nrst       (NRST),
      .load       (start_sel),
      .step       (step),
      .start_addr (r_addr),
      .interleave (BURST_ORDER_SEL),
      .cur_addr   (cur_addr)
   );
   wire [`SRAM_ADDR_W-1:0] acc_addr = start_sel ? r_addr : cur_addr;

   // ==============================================================
   // array and read pipeline
   logic [`SRAM_DATA_W-1:0] mem [`SRAM_DEPTH];
   logic [`SRAM_DATA_W-1:0] rd_stage;
   logic rd_v1, rd_v2;

   // per-lane synchronous write
   genvar g;
   generate
      for (g = 0; g < `SRAM_LANES; g++) begin : g_lane
         always_ff @(posedge CLK) begin
            if (any_wr && lane_wr[g])
               mem[acc_addr][g*`SRAM_LANE_W +: `SRAM_LANE_W]
                  <= r_din[g*`SRAM_LANE_W +: `SRAM_LANE_W];
         end
      end
   endgenerate

   // two stage read: array to stage, stage to output
   wire rd_now = awake && (start ? sel_ok : active) && !any_wr;
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         rd_stage <= '0;
         DQ_OUT   <= '0;
         rd_v1    <= 1'b0;
         rd_v2    <= 1'b0;
      end else if (awake) begin
         rd_stage <= mem[acc_addr];
         DQ_OUT   <= rd_stage;
         rd_v1    <= rd_now;
         rd_v2    <= rd_v1 && !deselect;
      end else begin
         rd_v1    <= 1'b0;
         rd_v2    <= 1'b0;
      end
   end

   // async output enable; writes and sleep force drivers off
   assign DQ_OE = rd_v2 && !OUT_ENABLE_N && !ASLEEP && !any_wr;

   AST_GW_ALL: assert property (@(posedge CLK) disable iff (!NRST)
      !r_gw_n |-> lane_wr == {`SRAM_LANES{1'b1}})
      else $error("global write missed a lane");
   AST_BLOCK_CPU_ADDR_STROBE_N: assert property (@(posedge CLK) disable iff (!NRST)
      (r_cs1_n && r_ctrl_addr_strobe_n_n) |-> !start)
      else $error("blocked strobe started a cycle");
   AST_TWO_CYC: assert property (@(posedge CLK) disable iff (!NRST)
      (rd_now && !SLEEP_REQ) ##1 (!deselect && !SLEEP_REQ) |=> rd_v2)
      else $error("read not valid two edges later");
   AST_SLEEP_OFF: assert property (@(posedge CLK) disable iff (!NRST)
      SLEEP_REQ |-> !DQ_OE)
      else $error("drivers on during sleep");
   AST_WAKE: assert property (@(posedge CLK) disable iff (!NRST)
      (pwr == ST_SLEEP && !SLEEP_REQ) ##1 !SLEEP_REQ[*2] |=> !ASLEEP)
      else $error("wake-up not two cycles");
   AST_OE_ASYNC: assert property (@(posedge CLK) disable iff (!NRST)
      OUT_ENABLE_N |-> !DQ_OE)
      else $error("drivers on with output enable high");
endmodule // burst_sram

// >>> verilog/burst_sram_cfg.svh
// constants and functional notes for the pipelined burst memory
// Functional notes
// - array of 64K words, 36 bits wide, 16-bit address
// - two-bit internal counter forms the low address bits of a burst
// - reads pass two pipeline stages; a burst is four accesses
// - global write low writes every byte lane
// - otherwise lanes written where byte gate and lane write are both low
// - primary select high blocks the processor address strobe
// - either address strobe starts a burst with external address
// - later burst addresses advance only when advance input is low
// - static order select picks linear or interleaved sequence
// - sleep input forces power-down regardless of the clock
// - writes are captured on the clock edge and self-timed
// - three selects; enable shows two cycles later, disable one cycle
// - output enable gates data drivers without a clock edge
// - address and control inputs are registered before use
// - two wake-up cycles after sleep ends, state kept
// - linear adds beat count mod four; interleaved xors beat count
// - counter wraps to the external start value after four beats
`ifndef BURST_SRAM_CFG_SVH
`define BURST_SRAM_CFG_SVH
`define SRAM_ADDR_W     16
`define SRAM_DATA_W     36
`define SRAM_LANES      4
`define SRAM_LANE_W     9
`define SRAM_DEPTH      65536
`define SRAM_WAKE_CYC   2'h2
`endif

// >>> verilog/burst_sram_pkg.sv
// types shared by the burst memory design
package burst_sram_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SLEEP, ST_WAKE} pwr_state_t;
   typedef logic [1:0] beat_t;
endpackage

// >>> verilog/burst_addr_gen.sv
// burst address counter and sequencer
`timescale 1ns/1ps
`include "burst_sram_cfg.svh"
module burst_addr_gen
   import burst_sram_pkg::*;
(
   input  wire logic                    clk,         // clock
   input  wire logic                    nrst,        // sync reset, low
   input  wire logic                    load,        // new start address
   input  wire logic                    step,        // advance one beat
   input  wire logic [`SRAM_ADDR_W-1:0] start_addr,  // external address
   input  wire logic                    interleave,  // order select
   output logic      [`SRAM_ADDR_W-1:0] cur_addr     // address in use
);
   timeunit 1ns;
   logic [`SRAM_ADDR_W-1:0] base;
   beat_t                   beat;
   beat_t                   low_bits;
   beat_t                   eff_beat;

   // beat used this cycle; an advance takes effect on this access
   assign eff_beat = step ? beat_t'(beat + 2'h1) : beat;

   // low address bits from start and beat count
   assign low_bits = interleave ? (base[1:0] ^ eff_beat)
                                : beat_t'(base[1:0] + eff_beat);
   assign cur_addr = {base[`SRAM_ADDR_W-1:2], low_bits};

   // two-bit beat counter, wraps naturally to start
   always_ff @(posedge clk) begin
      if (!nrst) begin
         base <= '0;
         beat <= 2'h0;
      end else if (load) begin
         base <= start_addr;
         beat <= 2'h0;
      end else if (step) begin
         beat <= eff_beat;
      end
   end

   AST_WRAP: assert property (@(posedge clk) disable iff (!nrst)
      (!load && step && beat == 2'h3) |=> beat == 2'h0)
      else $error("burst counter did not wrap");
   AST_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      (!load && !step) |=> ($stable(base) && $stable(beat)))
      else $error("address moved without advance");
endmodule // burst_addr_gen

// >>> verif/proc_bus_model.sv
// processor-side data bus model facing the burst memory
`timescale 1ns/1ps
// =====
// bus model
module proc_bus_model (
   input  wire logic        clk,        // bus clock
   input  wire logic        dev_drive,  // memory drives
   input  wire logic [35:0] dev_data,   // memory data
   input  wire logic        host_drive, // processor drives
   input  wire logic [35:0] host_data,  // processor data
   output logic      [35:0] bus,        // resolved level
   output logic             clash       // both driving
);
   logic [35:0] last;
   // released bus toggles so stale data never looks valid
   always_comb begin
      if (dev_drive) bus = dev_data;
      else if (host_drive) bus = host_data;
      else bus = ~last;
   end
   assign clash = dev_drive && host_drive;
   // remember level for the release pattern
   always_ff @(posedge clk) begin
      last <= bus;
   end
endmodule // proc_bus_model

// >>> verif/testbench.sv
// self-checking bench for the pipelined burst memory
`timescale 1ns/1ps
`include "burst_sram_cfg.svh"
// =====
// bench top
module testbench
   import burst_sram_pkg::*;
;
   logic clk, nrst, cpu_n, ctrl_n, adv_n, gw_n, bg_n, hdrv;
   logic sel1_n, sel2, sel3_n, oe_n, order, sleep;
   logic [3:0] lane_n;
   logic [15:0] addr;
   logic [35:0] hdata, bus, dq_out;
   logic [35:0] shadow [logic [15:0]];
   logic [35:0] expq [$];
   logic dq_oe, asleep, clash;
   int n_mismatch = 0;
   int compares = 0;
   int seed = 24;
   burst_sram u_dut (.CLK(clk), .NRST(nrst), .ADDR(addr),
      .CPU_ADDR_STROBE_N(cpu_n), .CTRL_ADDR_STROBE_N(ctrl_n),
      .BURST_ADVANCE_N(adv_n), .GLOBAL_WRITE_N(gw_n),
      .BYTE_WRITE_GATE_N(bg_n), .LANE_WRITE_N(lane_n),
      .PRIMARY_SELECT_N(sel1_n), .SECONDARY_SELECT(sel2),
      .TERTIARY_SELECT_N(sel3_n), .OUT_ENABLE_N(oe_n),
      .BURST_ORDER_SEL(order), .SLEEP_REQ(sleep), .DQ_IN(bus),
      .DQ_OUT(dq_out), .DQ_OE(dq_oe), .ASLEEP(asleep));
   proc_bus_model u_bus (.clk(clk), .dev_drive(dq_oe), .dev_data(dq_out),
      .host_drive(hdrv), .host_data(hdata), .bus(bus), .clash(clash));
   // clock
   always #4 clk = ~clk;
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   function automatic logic [35:0] rnd();
      logic [63:0] r;
      r = {$random(seed), $random(seed)};
      return r[35:0];
   endfunction
   // inactive controls; processor strobe high
   task automatic idle();
      cpu_n = 1'b1;
      ctrl_n = 1'b1;
      adv_n = 1'b1;
      gw_n = 1'b1;
      bg_n = 1'b1;
      lane_n = 4'hf;
      hdrv = 1'b0;
      oe_n = 1'b1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [35:0] d,
                     input logic g, input logic b, input logic [3:0] l);
      logic [35:0] m;
      m = '0;
      for (int k = 0; k < 4; k++)
         if (!g || (!b && !l[k])) m[9*k +: 9] = 9'h1ff;
      addr = a;
      ctrl_n = 1'b0;
      gw_n = g;
      bg_n = b;
      lane_n = l;
      hdrv = 1'b1;
      hdata = d;
      if (!sleep) shadow[a] = (shadow[a] & ~m) | (d & m);
      tick();
      idle();
      tick();
   endtask
   task automatic rd(input logic [15:0] a, input logic p, input int n,
                     input logic ok);
      logic [1:0] lo;
      for (int b = 0; b < n && ok; b++) begin
         lo = order ? a[1:0] ^ b[1:0] : a[1:0] + b[1:0];
         expq.push_back(shadow[{a[15:2], lo}]);
      end
      for (int i = 0; i < n + 4; i++) begin
         addr = a;
         cpu_n = !(p && i == 0);
         ctrl_n = !(!p && i == 0);
         adv_n = !(i >= 1 && i < n);
         oe_n = !(i >= 3 && i < n + 3);
         tick();
      end
   endtask
   // output monitor against the oldest note
   always @(negedge clk) begin
      check({35'h0, clash}, 36'h0);
      if (dq_oe === 1'b1) begin
         if (expq.size() == 0) check(dq_out, 36'hx);
         else check(dq_out, expq.pop_front());
      end
   end
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   // main sequence
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      order = 1'b0;
      sleep = 1'b0;
      sel1_n = 1'b0;
      sel2 = 1'b1;
      sel3_n = 1'b0;
      addr = '0;
      hdata = '0;
      idle();
      repeat (8) tick();
      nrst = 1'b1;
      for (int w = 0; w < 4; w++) begin
         wr(16'h0100 + w[15:0], rnd(), 1'b0, 1'b0, 4'(rnd()));
         wr(16'hfffc + w[15:0], rnd(), 1'b0, 1'b1, 4'hf);
      end
      wr(16'h0101, rnd(), 1'b1, 1'b0, 4'b1010);
      wr(16'h0102, rnd(), 1'b1, 1'b1, 4'h0);
      $display("test writes done");
      for (int o = 0; o < 2; o++) begin
         order = o[0];
         for (int s = 0; s < 4; s++) rd(16'h0100 + s[15:0], s[0], 4, 1'b1);
         rd(16'hfffd, 1'b0, 5, 1'b1);
      end
      order = 1'b0;
      $display("test bursts done");
      sel2 = 1'b0;
      rd(16'h0100, 1'b0, 1, 1'b0);
      sel2 = 1'b1;
      sel3_n = 1'b1;
      rd(16'h0100, 1'b0, 1, 1'b0);
      sel3_n = 1'b0;
      sel1_n = 1'b1;
      rd(16'h0100, 1'b1, 1, 1'b0);
      sel1_n = 1'b0;
      rd(16'h0103, 1'b1, 1, 1'b1);
      $display("test selects done");
      sleep = 1'b1;
      #1 check({35'h0, asleep}, 36'h1);
      wr(16'h0100, rnd(), 1'b0, 1'b1, 4'hf);
      sleep = 1'b0;
      tick();
      tick();
      check({35'h0, asleep}, 36'h1);
      tick();
      check({35'h0, asleep}, 36'h0);
      rd(16'h0100, 1'b1, 1, 1'b1);
      $display("test sleep done");
      for (int t = 0; t < 20 && expq.size() > 0; t++) tick();
      if (expq.size() > 0) check(36'h0, 36'h1);
      conclude();
   end
endmodule // testbench
